/* src/ebac_pkg.sv */
/*
 * constants shared by the eeprom byte access controller and its programming timer.
 * assumes a cpu clock of 200 MHz and a 6-bit i/o register address space.
 */
package ebac_pkg;

   // address and data widths of the nonvolatile array
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;

   // i/o register addresses
   localparam logic [5:0] IO_NV_ADDR_LOW  = 6'h21;
   localparam logic [5:0] IO_NV_ADDR_HIGH = 6'h22;
   localparam logic [5:0] IO_NV_DATA_BYTE = 6'h23;
   localparam logic [5:0] IO_NV_CONTROL   = 6'h24;

   // nv_control field positions
   localparam int CTRL_READ_STROBE  = 0;
   localparam int CTRL_WRITE_STROBE = 1;
   localparam int CTRL_MASTER_ARM   = 2;
   localparam int CTRL_IRQ_ENABLE   = 3;
   localparam int CTRL_MODE_LO      = 4;
   localparam int CTRL_MODE_HI      = 5;

   // programming modes
   typedef enum logic [1:0] {
      EBAC_MODE_ATOMIC   = 2'h0,
      EBAC_MODE_ERASE    = 2'h1,
      EBAC_MODE_WRITE    = 2'h2,
      EBAC_MODE_RESERVED = 2'h3
   } ebac_mode_t;

   // programming engine states, gray along idle -> prog
   typedef enum logic [1:0] {
      EBAC_ENG_IDLE = 2'h0,
      EBAC_ENG_PROG = 2'h1
   } ebac_eng_state_t;

   // reset values
   localparam logic [1:0]  RESET_MODE = 2'h0;
   localparam logic [8:0]  RESET_ADDR = 9'h000;
   localparam logic [7:0]  RESET_DATA = 8'h00;

   // cpu-clock timing in cycles
   localparam logic [2:0] ARM_WINDOW_CYCLES  = 3'h4;
   localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
   localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;

   // programming times in microseconds, and rc-oscillator cycle counts
   localparam int ATOMIC_TIME_US    = 3400;
   localparam int SPLIT_TIME_US     = 1800;
   localparam int TYP_WRITE_TIME_US = 3300;
   localparam int RC_CYCLES_ATOMIC  = 26368;
   localparam int RC_CYCLES_SPLIT   = RC_CYCLES_ATOMIC * SPLIT_TIME_US / ATOMIC_TIME_US;
   localparam int RC_COUNT_W        = 15;

endpackage

/* src/ebac_prog_timer.sv */
/*
 * programming engine: latches one request and times it from the rc oscillator.
 * assumes rc_osc arrives unsynchronised and is much slower than clock;
 * reset only by power-on, so a system reset never cuts a write short.
 */
`timescale 1ns/10ps
module ebac_prog_timer #(
   parameter int ATOMIC_RC_CYCLES = ebac_pkg::RC_CYCLES_ATOMIC,
   parameter int SPLIT_RC_CYCLES  = ebac_pkg::RC_CYCLES_SPLIT
) (
   // clock and power-on reset
   input  wire logic       clock,
   input  wire logic       por,
   // rc oscillator pin
   input  wire logic       rc_osc,
   // start request
   input  wire logic       start,
   input  wire logic [1:0] start_mode,
   input  wire logic [8:0] start_addr,
   input  wire logic [7:0] start_data,
   // engine state
   output logic            busy,
   output logic [1:0]      mode,
   output logic [8:0]      addr,
   output logic [7:0]      data
);
   typedef struct packed {
      logic [2:0]                     sync;
      logic                           level;
      ebac_pkg::ebac_eng_state_t      st;
      logic [ebac_pkg::RC_COUNT_W-1:0] count;
      logic [1:0]                     mode;
      logic [8:0]                     addr;
      logic [7:0]                     data;
      logic                           busy;
   } ebac_timer_state_t;

   ebac_timer_state_t s;
   ebac_timer_state_t next_s;
   logic              agree;
   logic              tick;
   logic [ebac_pkg::RC_COUNT_W-1:0] last;

   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], rc_osc};
      // only the second and third stage are looked at
      agree = (s.sync[1] == s.sync[2]);
      tick = agree && s.sync[2] && !s.level;
      if (agree) begin
         next_s.level = s.sync[2];
      end
      if (s.mode == ebac_pkg::EBAC_MODE_ATOMIC) begin
         last = ebac_pkg::RC_COUNT_W'(ATOMIC_RC_CYCLES - 1);
      end else begin
         last = ebac_pkg::RC_COUNT_W'(SPLIT_RC_CYCLES - 1);
      end
      case (s.st)
         ebac_pkg::EBAC_ENG_IDLE: begin
            if (start) begin
               next_s.st = ebac_pkg::EBAC_ENG_PROG;
               next_s.busy = 1'b1;
               next_s.count = '0;
               next_s.mode = start_mode;
               next_s.addr = start_addr;
               next_s.data = start_data;
            end
         end
         ebac_pkg::EBAC_ENG_PROG: begin
            if (tick) begin
               if (s.count == last) begin
                  next_s.st = ebac_pkg::EBAC_ENG_IDLE;
                  next_s.busy = 1'b0;
               end else begin
                  next_s.count = s.count + 1'b1;
               end
            end
         end
         default: begin
            next_s.st = ebac_pkg::EBAC_ENG_IDLE;
            next_s.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or posedge por) begin
      if (por) begin
         s <= '{sync: 3'h0, level: 1'b0, st: ebac_pkg::EBAC_ENG_IDLE, count: '0,
                mode: ebac_pkg::RESET_MODE, addr: ebac_pkg::RESET_ADDR,
                data: ebac_pkg::RESET_DATA, busy: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign mode = s.mode;
   assign addr = s.addr;
   assign data = s.data;
endmodule

/* src/ebac_ctrl.sv */
/*
 * eeprom byte access controller: address, data and control registers on the
 * cpu i/o port, read path, guarded write start, cpu stall and ready interrupt.
 * assumes a combinational array read port on mem_rd_addr/mem_rdata, a cpu
 * that honours cpu_stall, and a power-on reset distinct from system reset.
 */
// Overview of operation
// - nine-bit linear byte address over two registers, high register upper bits read zero.
// - data register holds byte to program, and receives the byte read.
// - mode field selects atomic, erase only or write only; code 11 reserved.
// - mode field writes are ignored while the write strobe is busy.
// - reset returns mode to 00 unless programming is still in progress.
// - ready interrupt level while idle, enabled, global flag set and no flash self-programming active.
// - master arm bit clears itself four clock cycles after being set.
// - write strobe starts programming only while the master arm bit is set.
// - no programming start while flash self-programming is active.
// - hardware clears the write strobe when programming time has elapsed.
// - cpu is stalled two cycles when programming starts.
// - read strobe loads data register at once and stalls cpu four cycles.
// - no reads and no address changes while a write is in progress.
// - programming time counted in calibrated rc oscillator cycles, 26368 for atomic, 13959 for erase only or write only.
// - a write in progress completes across a system reset.
`timescale 1ns/10ps
module ebac_ctrl #(
   parameter int ATOMIC_RC_CYCLES = ebac_pkg::RC_CYCLES_ATOMIC,
   parameter int SPLIT_RC_CYCLES  = ebac_pkg::RC_CYCLES_SPLIT
) (
   // clock and resets
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       por,
   // cpu i/o register port
   input  wire logic [5:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic [7:0]      io_rdata,
   // cpu side status
   input  wire logic       global_irq_flag,
   input  wire logic       flash_selfprog_busy,
   output logic            cpu_stall,
   output logic            ready_irq,
   // rc oscillator pin
   input  wire logic       rc_osc,
   // array read port
   output logic [8:0]      mem_rd_addr,
   input  wire logic [7:0] mem_rdata,
   // array programming port
   output logic            prog_active,
   output logic [1:0]      prog_mode,
   output logic [8:0]      prog_addr,
   output logic [7:0]      prog_data
);

   typedef struct packed {
      logic [8:0] nv_byte_address;
      logic [7:0] nv_data_byte;
      logic [1:0] prog_mode;
      logic       ready_irq_enable;
      logic       master_write_arm;
      logic [2:0] arm_left;
      logic [2:0] stall_left;
      logic       stall;
      logic       irq;
      logic [7:0] rdata;
      logic       start;
   } ebac_ctrl_state_t;

   localparam ebac_ctrl_state_t RESET_STATE = '{
      nv_byte_address:  ebac_pkg::RESET_ADDR,
      nv_data_byte:     ebac_pkg::RESET_DATA,
      prog_mode:        ebac_pkg::RESET_MODE,
      ready_irq_enable: 1'b0,
      master_write_arm: 1'b0,
      arm_left:         3'h0,
      stall_left:       3'h0,
      stall:            1'b0,
      irq:              1'b0,
      rdata:            8'h00,
      start:            1'b0
   };

   ebac_ctrl_state_t s;
   ebac_ctrl_state_t next_s;

   // programming engine view
   logic       eng_busy;
   logic [1:0] eng_mode;
   logic [8:0] eng_addr;
   logic [7:0] eng_data;

   // decoded strobes
   logic       wr_low;
   logic       wr_high;
   logic       wr_data;
   logic       wr_ctrl;
   logic       busy_now;
   logic [1:0] mode_view;
   logic [1:0] mode_written;
   logic       start_ok;
   logic       read_ok;
   logic [2:0] stall_load;

   // a start already issued counts as busy before the engine reports it
   assign busy_now = eng_busy | s.start;

   // mode readback follows the engine while it runs
   assign mode_view = eng_busy ? eng_mode : s.prog_mode;

   always_comb begin
      wr_low  = io_wr && (io_addr == ebac_pkg::IO_NV_ADDR_LOW);
      wr_high = io_wr && (io_addr == ebac_pkg::IO_NV_ADDR_HIGH);
      wr_data = io_wr && (io_addr == ebac_pkg::IO_NV_DATA_BYTE);
      wr_ctrl = io_wr && (io_addr == ebac_pkg::IO_NV_CONTROL);
   end

   // mode as it stands after this cycle's write
   always_comb begin
      mode_written = s.prog_mode;
      if (wr_ctrl && !busy_now) begin
         mode_written = io_wdata[ebac_pkg::CTRL_MODE_HI:ebac_pkg::CTRL_MODE_LO];
      end
   end

   // write start qualification
   always_comb begin
      start_ok = wr_ctrl
               && io_wdata[ebac_pkg::CTRL_WRITE_STROBE]
               && s.master_write_arm
               && !busy_now
               && !flash_selfprog_busy
               && (mode_written != ebac_pkg::EBAC_MODE_RESERVED);
   end

   // read strobe qualification
   always_comb begin
      read_ok = wr_ctrl
              && io_wdata[ebac_pkg::CTRL_READ_STROBE]
              && !busy_now;
   end

   // longer stall wins when both strobes arrive together
   always_comb begin
      stall_load = 3'h0;
      if (start_ok) begin
         stall_load = ebac_pkg::WRITE_STALL_CYCLES;
      end
      if (read_ok) begin
         stall_load = ebac_pkg::READ_STALL_CYCLES;
      end
   end

   always_comb begin
      next_s = s;
      next_s.start = 1'b0;

      // master arm times out
      if (s.master_write_arm) begin
         if (s.arm_left == 3'h1) begin
            next_s.master_write_arm = 1'b0;
            next_s.arm_left = 3'h0;
         end else begin
            next_s.arm_left = s.arm_left - 3'h1;
         end
      end

      // stall countdown
      if (s.stall_left != 3'h0) begin
         next_s.stall_left = s.stall_left - 3'h1;
      end

      // mode is frozen to the engine copy while programming
      if (eng_busy) begin
         next_s.prog_mode = eng_mode;
      end

      // address registers
      if (wr_low && !busy_now) begin
         next_s.nv_byte_address[7:0] = io_wdata;
      end
      if (wr_high && !busy_now) begin
         next_s.nv_byte_address[8] = io_wdata[0];
      end

      // data register written by the cpu
      if (wr_data) begin
         next_s.nv_data_byte = io_wdata;
      end

      // control register
      if (wr_ctrl) begin
         next_s.ready_irq_enable = io_wdata[ebac_pkg::CTRL_IRQ_ENABLE];
         next_s.prog_mode = mode_written;
         if (start_ok) begin
            next_s.start = 1'b1;
            next_s.master_write_arm = 1'b0;
            next_s.arm_left = 3'h0;
         end else if (io_wdata[ebac_pkg::CTRL_MASTER_ARM]) begin
            // writing zero leaves a running arm alone; only the timeout or an accepted start ends it
            next_s.master_write_arm = 1'b1;
            next_s.arm_left = ebac_pkg::ARM_WINDOW_CYCLES;
         end
      end

      // read fetch lands in the data register the same cycle
      if (read_ok) begin
         next_s.nv_data_byte = mem_rdata;
      end

      if (stall_load != 3'h0) begin
         next_s.stall_left = stall_load;
      end
      next_s.stall = (next_s.stall_left != 3'h0);

      // ready interrupt, a level for as long as the engine is idle
      next_s.irq = next_s.ready_irq_enable
                 && global_irq_flag
                 && !(eng_busy || next_s.start)
                 && !flash_selfprog_busy;

      // registered readback, answered one cycle after io_rd
      next_s.rdata = 8'h00;
      if (io_rd) begin
         case (io_addr)
            ebac_pkg::IO_NV_ADDR_LOW: begin
               next_s.rdata = s.nv_byte_address[7:0];
            end
            ebac_pkg::IO_NV_ADDR_HIGH: begin
               next_s.rdata = {7'h00, s.nv_byte_address[8]};
            end
            ebac_pkg::IO_NV_DATA_BYTE: begin
               next_s.rdata = s.nv_data_byte;
            end
            ebac_pkg::IO_NV_CONTROL: begin
               next_s.rdata = {2'h0, mode_view, s.ready_irq_enable,
                               s.master_write_arm, busy_now, 1'b0};
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end
   end

   // system reset leaves the engine alone; mode readback then follows it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // timing is on the rc oscillator so it does not depend on the cpu clock rate
   ebac_prog_timer #(
      .ATOMIC_RC_CYCLES (ATOMIC_RC_CYCLES),
      .SPLIT_RC_CYCLES  (SPLIT_RC_CYCLES)
   ) u_timer (
      .clock      (clock),
      .por        (por),
      .rc_osc     (rc_osc),
      .start      (s.start),
      .start_mode (s.prog_mode),
      .start_addr (s.nv_byte_address),
      .start_data (s.nv_data_byte),
      .busy       (eng_busy),
      .mode       (eng_mode),
      .addr       (eng_addr),
      .data       (eng_data)
   );

   // outputs
   assign io_rdata    = s.rdata;
   assign cpu_stall   = s.stall;
   assign ready_irq   = s.irq;
   assign mem_rd_addr = s.nv_byte_address;
   assign prog_active = eng_busy;
   assign prog_mode   = eng_mode;
   assign prog_addr   = eng_addr;
   assign prog_data   = eng_data;

endmodule

/* test/ebac_ctrl_props.sv */
/* port checker for ebac_ctrl: reads, stalls, write start, busy guards, irq.
   assumes one clock domain, rst disabling, a cpu that waits out cpu_stall. */
`timescale 1ns/10ps
module ebac_ctrl_props (
   // clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // cpu port
   input wire logic [5:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // status
   input wire logic       global_irq_flag,
   input wire logic       flash_selfprog_busy,
   input wire logic       cpu_stall,
   input wire logic       ready_irq,
   // array side
   input wire logic [8:0] mem_rd_addr,
   input wire logic       prog_active,
   input wire logic [1:0] prog_mode,
   input wire logic [8:0] prog_addr
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [2:0] arm_age;
   logic       ctl_wr;
   logic       idle;
   assign ctl_wr = io_wr && io_addr == ebac_pkg::IO_NV_CONTROL;
   assign idle   = !prog_active && !cpu_stall;
   // cycles since last arm write; saturates so stale arms never look live
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         arm_age <= 3'h7;
      end else if (ctl_wr && io_wdata[2]) begin
         arm_age <= 3'h0;
      end else if (arm_age != 3'h7) begin
         arm_age <= arm_age + 3'h1;
      end
   end
   sequence seq_start;
      ctl_wr && io_wdata[1:0] == 2'h2 && arm_age < 3'h4 && idle && !flash_selfprog_busy
         && io_wdata[5:4] != 2'h3;
   endsequence
   sequence seq_read;
      ctl_wr && io_wdata[1:0] == 2'h1 && idle;
   endsequence
   chk_addr_high:
   assert property (io_rd && io_addr == ebac_pkg::IO_NV_ADDR_HIGH |=> io_rdata[7:1] == 7'h0)
      else $error("address high upper bits not zero");
   chk_read_stall:
   assert property (seq_read |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall length wrong");
   chk_write_stall:
   assert property (seq_start |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall length wrong");
   chk_prog_start:
   assert property (seq_start |-> ##2 prog_active && prog_addr == $past(mem_rd_addr, 2))
      else $error("armed strobe did not start programming");
   chk_refuse_start:
   assert property (ctl_wr && io_wdata[1] && idle && (arm_age > 3'h3 || flash_selfprog_busy)
      |=> !prog_active [*2]) else $error("unarmed or blocked strobe started");
   chk_busy_ctrl:
   assert property (prog_active && io_rd && io_addr == ebac_pkg::IO_NV_CONTROL
      |=> io_rdata[5:4] == prog_mode && io_rdata[1]) else $error("busy control read wrong");
   chk_busy_addr:
   assert property (prog_active && io_wr && io_addr == ebac_pkg::IO_NV_ADDR_LOW
      |=> mem_rd_addr == $past(mem_rd_addr)) else $error("address changed while busy");
   chk_irq_quiet:
   assert property ($past(prog_active) || !$past(global_irq_flag) || $past(flash_selfprog_busy)
      |-> !ready_irq) else $error("ready irq while blocked");
   chk_prog_time:
   assert property ($rose(prog_active) |-> prog_active [*8] ##[1:600] !prog_active)
      else $error("programming time out of range");
endmodule

bind ebac_ctrl ebac_ctrl_props u_props (.clock(clock), .rst(rst), .io_addr(io_addr),
   .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
   .global_irq_flag(global_irq_flag), .flash_selfprog_busy(flash_selfprog_busy),
   .cpu_stall(cpu_stall), .ready_irq(ready_irq), .mem_rd_addr(mem_rd_addr),
   .prog_active(prog_active), .prog_mode(prog_mode), .prog_addr(prog_addr));

/* test/ebac_ctrl_bench.sv */
/* self-checking bench for ebac_ctrl: register map, read, write modes, guards, reset.
   assumes a combinational array image and shortened rc counts (8 and 4). */
`timescale 1ns/10ps
module ebac_ctrl_bench;
   localparam logic [5:0] A_LO  = ebac_pkg::IO_NV_ADDR_LOW;
   localparam logic [5:0] A_HI  = ebac_pkg::IO_NV_ADDR_HIGH;
   localparam logic [5:0] A_DAT = ebac_pkg::IO_NV_DATA_BYTE;
   localparam logic [5:0] A_CTL = ebac_pkg::IO_NV_CONTROL;
   // stimulus
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       por = 1'b1;
   logic       rc_osc = 1'b0;
   logic [5:0] io_addr = 6'h00;
   logic       io_wr = 1'b0;
   logic       io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic       global_irq_flag = 1'b0;
   logic       flash_selfprog_busy = 1'b0;
   // observed
   logic [7:0] io_rdata;
   logic       cpu_stall;
   logic       ready_irq;
   logic [8:0] mem_rd_addr;
   logic [7:0] mem_rdata;
   logic       prog_active;
   logic [1:0] prog_mode;
   logic [8:0] prog_addr;
   logic [7:0] prog_data;
   int         bad_count = 0;
   int         tests_run = 0;
   int         cyc = 0;
   always #2.5 clock = ~clock;
   // rc free running, slow and out of phase with clock
   always #20.3 rc_osc = ~rc_osc;
   function automatic logic [7:0] img(logic [8:0] a);
      return a[7:0] ^ 8'h5a ^ {7'h0, a[8]};
   endfunction
   assign mem_rdata = img(mem_rd_addr);
   ebac_ctrl #(.ATOMIC_RC_CYCLES(8), .SPLIT_RC_CYCLES(4)) u_dut (.clock(clock), .rst(rst),
      .por(por), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .global_irq_flag(global_irq_flag),
      .flash_selfprog_busy(flash_selfprog_busy), .cpu_stall(cpu_stall),
      .ready_irq(ready_irq), .rc_osc(rc_osc), .mem_rd_addr(mem_rd_addr),
      .mem_rdata(mem_rdata), .prog_active(prog_active), .prog_mode(prog_mode),
      .prog_addr(prog_addr), .prog_data(prog_data));
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic check(logic [8:0] seen, logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // cpu waits out any stall before its next access
   task automatic wr(logic [5:0] a, logic [7:0] d);
      do @(posedge clock); while (cpu_stall === 1'b1);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
   endtask
   task automatic rdc(logic [5:0] a, logic [7:0] exp);
      do @(posedge clock); while (cpu_stall === 1'b1);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      #1 check({1'b0, io_rdata}, {1'b0, exp});
   endtask
   task automatic idle_wait();
      int n;
      n = 0;
      while (prog_active === 1'b1 && n < 800) begin
         @(posedge clock);
         n++;
      end
      check(prog_active, 1'b0);
   endtask
   task automatic no_start();
      repeat (3) @(posedge clock);
      check(prog_active, 1'b0);
   endtask
   task automatic t_regs();
      rdc(A_LO, 8'h00);
      wr(A_HI, 8'hff);
      rdc(A_HI, 8'h01);
      wr(A_CTL, 8'hc8);
      rdc(A_CTL, 8'h08);
      rdc(6'h25, 8'h00);
      $display("regs test done");
   endtask
   task automatic t_read();
      wr(A_LO, 8'ha5);
      wr(A_CTL, 8'h01);
      rdc(A_DAT, img(9'h1a5));
      rdc(A_CTL, 8'h00);
      $display("read test done");
   endtask
   task automatic t_write();
      logic [7:0] c;
      for (int m = 0; m < 3; m++) begin
         c = {2'h0, m[1:0], 4'h8};
         wr(A_LO, 8'h30 + m[7:0]);
         wr(A_DAT, 8'hc0 + m[7:0]);
         wr(A_CTL, c | 8'h04);
         wr(A_CTL, c | 8'h02);
         global_irq_flag <= 1'b1;
         // address, mode and read strobe all refused while busy
         wr(A_LO, 8'h00);
         wr(A_CTL, 8'h39);
         check(prog_active, 1'b1);
         check({7'h0, prog_mode}, {7'h0, m[1:0]});
         check(prog_addr, {1'b1, 8'h30 + m[7:0]});
         check({1'b0, prog_data}, {1'b0, 8'hc0 + m[7:0]});
         check(ready_irq, 1'b0);
         rdc(A_CTL, c | 8'h02);
         rdc(A_DAT, 8'hc0 + m[7:0]);
         rdc(A_LO, 8'h30 + m[7:0]);
         idle_wait();
         rdc(A_CTL, c);
         check(ready_irq, 1'b1);
         global_irq_flag <= 1'b0;
      end
      $display("write test done");
   endtask
   task automatic t_refuse();
      wr(A_CTL, 8'h34);
      wr(A_CTL, 8'h32);
      no_start();
      wr(A_CTL, 8'h02);
      no_start();
      wr(A_CTL, 8'h04);
      // arm accepts strobes at the four edges after it; this one lands on the fifth
      repeat (3) @(posedge clock);
      wr(A_CTL, 8'h02);
      no_start();
      flash_selfprog_busy <= 1'b1;
      wr(A_CTL, 8'h04);
      wr(A_CTL, 8'h02);
      no_start();
      flash_selfprog_busy <= 1'b0;
      $display("refuse test done");
   endtask
   task automatic t_reset();
      wr(A_HI, 8'h00);
      rdc(A_HI, 8'h00);
      wr(A_CTL, 8'h14);
      wr(A_CTL, 8'h12);
      repeat (3) @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      check(prog_active, 1'b1);
      rdc(A_CTL, 8'h12);
      idle_wait();
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      rdc(A_CTL, 8'h00);
      $display("reset test done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      por <= 1'b0;
      t_regs();
      t_read();
      t_write();
      t_refuse();
      t_reset();
      give_verdict();
   end
endmodule
